// file: pkg/bcrtc_pkg.sv
`default_nettype none
package bcrtc_pkg;
	// prescaler and shift
	localparam int PREDIV_W = 15;
	localparam logic [14:0] PREDIV_RST = 15'h7FFF;
	localparam int SHIFT_W = 15;
	// one masked pulse per 2^20 pulses is about 0.95 ppm
	localparam int CAL_W = 20;
	localparam int CALM_W = 9;
	localparam logic [10:0] CAL_SLOT = 11'h000;
	// fast source divided by 32
	localparam logic [4:0] FAST_DIV_TOP = 5'h1F;
	// reference input: edges per second minus one, and the lock window
	localparam logic [5:0] REF_TOP_50 = 6'h31;
	localparam logic [5:0] REF_TOP_60 = 6'h3B;
	localparam logic [14:0] REF_WIN = 15'h0100;
	// wakeup timer
	localparam int WAKE_W = 17;
	localparam int WU_PRE_W = 4;
	// backup store
	localparam int BKP_WORDS = 20;
	localparam int BKP_AW = 5;
	localparam int BKP_DW = 32;
	// calendar limits in BCD
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] SEC_TOP = 8'h59;
	localparam logic [7:0] HOUR24_TOP = 8'h23;
	localparam logic [7:0] HOUR12_TOP = 8'h12;
	localparam logic [7:0] HOUR_ELEVEN = 8'h11;
	localparam logic [7:0] MONTH_TOP = 8'h12;
	localparam logic [7:0] MONTH_FEB = 8'h02;
	localparam logic [7:0] YEAR_TOP = 8'h99;
	localparam logic [2:0] WDAY_ONE = 3'h1;
	localparam logic [2:0] WDAY_TOP = 3'h7;
	// event vector width
	localparam int EV_N = 5;
	typedef enum logic [1:0] {
		SRC_XTAL = 2'b00,
		SRC_RC_A = 2'b01,
		SRC_RC_B = 2'b10,
		SRC_FAST = 2'b11
	} bcrtc_src_t;
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [2:0] wday;
		logic pm;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} bcrtc_cal_t;
	// skip bits: 0 sec, 1 min, 2 hour, 3 date are ignored when set
	typedef struct packed {
		logic [3:0] skip;
		logic [7:0] date;
		logic pm;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} bcrtc_alarm_t;
	localparam bcrtc_cal_t CAL_RST = '{year: 8'h00, month: 8'h01, date: 8'h01, wday: 3'h1,
		pm: 1'b0, hour: 8'h00, min: 8'h00, sec: 8'h00};
endpackage
`default_nettype wire

// file: rtl/bcrtc_bkp_mem.sv
`default_nettype none
module bcrtc_bkp_mem #(
	parameter int WORDS = 20,
	parameter int AW = 5,
	parameter int DW = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [WORDS];
	logic [DW-1:0] next_rdData;

	// addresses past the last word read as zero
	always_comb begin
		next_rdData = '0;
		if (rdAddr < AW'(WORDS)) begin
			next_rdData = mem[rdAddr];
		end
	end

	// storage takes no reset so contents survive system resets
	always_ff @(posedge core_clk) begin
		if (ce && wrEn && (wrAddr < AW'(WORDS))) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdData <= '0;
		end else if (ce) begin
			rdData <= next_rdData;
		end
	end
endmodule
`default_nettype wire

// file: rtl/bcrtc_in_filter.sv
`default_nettype none
module bcrtc_in_filter #(
	parameter int CNT_W = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic pinIn,
	input wire logic [1:0] filtSel,
	output logic evt
);
	logic s1, s2, filt, next_filt, next_evt;
	logic [CNT_W-1:0] cnt, next_cnt, need;

	// a new level is taken only after 1, 2, 4 or 8 agreeing samples
	always_comb begin
		need = CNT_W'(1) << filtSel;
		next_cnt = '0;
		next_filt = filt;
		if (s2 != filt) begin
			if ((cnt + CNT_W'(1)) >= need) begin
				next_filt = s2;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
		next_evt = next_filt && !filt;
	end

	// s1 feeds only s2: the pin is asynchronous
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			cnt <= '0;
			filt <= 1'b0;
			evt <= 1'b0;
		end else if (ce) begin
			s1 <= pinIn;
			s2 <= s1;
			cnt <= next_cnt;
			filt <= next_filt;
			evt <= next_evt;
		end
	end

	chk_filter_pass: assert property (@(posedge core_clk) disable iff (rst)
		(ce && filtSel == 2'b00 && s2 && !filt) |=> filt)
		else $error("unfiltered level not taken");
endmodule
`default_nettype wire

// file: rtl/bcrtc_top.sv
`default_nettype none
module bcrtc_top #(
	parameter int BKP_WORDS = bcrtc_pkg::BKP_WORDS,
	parameter int FILT_W = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic xtalPin,
	input wire logic rcAPin,
	input wire logic rcBPin,
	input wire logic fastPin,
	input wire logic refPin,
	input wire logic tamperPin,
	input wire logic tsPin,
	input wire bcrtc_pkg::bcrtc_src_t clkSel,
	input wire logic battMode,
	input wire logic shutdownMode,
	input wire logic [14:0] preDiv,
	input wire logic calLoad,
	input wire bcrtc_pkg::bcrtc_cal_t calIn,
	input wire logic hour12,
	input wire logic shiftReq,
	input wire logic [14:0] shiftAmount,
	input wire logic [8:0] calibMask,
	input wire logic refEnable,
	input wire logic ref60,
	input wire logic [1:0] tampFilt,
	input wire logic [1:0] tsFilt,
	input wire logic tsClear,
	input wire logic tampClear,
	input wire logic wuEnable,
	input wire logic [2:0] wuSel,
	input wire logic [15:0] wuReload,
	input wire logic wuClear,
	input wire logic [1:0] alarmEn,
	input wire bcrtc_pkg::bcrtc_alarm_t alarmA,
	input wire bcrtc_pkg::bcrtc_alarm_t alarmB,
	input wire logic [1:0] alarmClear,
	input wire logic [4:0] eventIe,
	input wire logic bkpWrEn,
	input wire logic [4:0] bkpWrAddr,
	input wire logic [31:0] bkpWrData,
	input wire logic [4:0] bkpRdAddr,
	output logic [31:0] bkpRdData,
	output var bcrtc_pkg::bcrtc_cal_t calOut,
	output logic [14:0] subSec,
	output var bcrtc_pkg::bcrtc_cal_t tsCal,
	output logic [14:0] tsSubSec,
	output logic tsFlag,
	output logic tsOvf,
	output logic tampFlag,
	output logic wuFlag,
	output logic [1:0] alarmFlag,
	output logic wakeReq,
	output logic rtcRunning,
	output logic shiftBusy,
	output logic refLocked
);
	// pin vector {fast, rcB, rcA, xtal, ref}
	logic [4:0] pinS1, pinS2, pinS3, pinEdge;
	logic [4:0] fastDiv, next_fastDiv;
	logic fastTick, srcPulse, runOk, rtcPulse;
	logic [19:0] calCnt, next_calCnt;
	logic [14:0] shiftPend, next_shiftPend, next_subSec, lateEdge;
	logic [5:0] refCnt, next_refCnt, refTop;
	logic calMasked, livePulse, swallow, effPulse, refSec, refForce, ssLate;
	logic secTick, next_secTick, next_refLocked, next_shiftBusy;
	bcrtc_pkg::bcrtc_cal_t next_cal, next_tsCal;
	logic rollDay;
	logic [7:0] dayTop;
	logic calStep, next_calStep, battD, tsEvt, tampEvt, tsTrig, wuTick, wuHit;
	logic [1:0] alarmHit, next_alarmFlag;
	logic [3:0] wuPre, next_wuPre;
	logic [16:0] wuCnt, next_wuCnt, wuReloadFull;
	logic [4:0] evFlags;
	logic [14:0] next_tsSubSec;
	logic next_tsFlag, next_tsOvf, next_tampFlag, next_wuFlag, next_wakeReq;

	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// leap year test works on the two BCD year digits
	function automatic logic [7:0] daysIn(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h04, 8'h06, 8'h09, 8'h11: daysIn = 8'h30;
			bcrtc_pkg::MONTH_FEB: daysIn = leap ? 8'h29 : 8'h28;
			default: daysIn = 8'h31;
		endcase
	endfunction

	function automatic logic almMatch(input bcrtc_pkg::bcrtc_alarm_t a,
		input bcrtc_pkg::bcrtc_cal_t c);
		almMatch = (a.skip[0] || a.sec == c.sec) && (a.skip[1] || a.min == c.min)
			&& (a.skip[2] || (a.hour == c.hour && a.pm == c.pm))
			&& (a.skip[3] || a.date == c.date);
	endfunction

	// source selection; the crystal survives battery mode, the others do not
	always_comb begin
		pinEdge = pinS2 & ~pinS3;
		next_fastDiv = fastDiv;
		fastTick = 1'b0;
		if (pinEdge[4]) begin
			next_fastDiv = fastDiv + 5'h01;
			fastTick = (fastDiv == bcrtc_pkg::FAST_DIV_TOP);
		end
		srcPulse = 1'b0;
		runOk = !battMode && !shutdownMode;
		case (clkSel)
			bcrtc_pkg::SRC_XTAL: begin
				srcPulse = pinEdge[1];
				runOk = 1'b1;
			end
			bcrtc_pkg::SRC_RC_A: srcPulse = pinEdge[2];
			bcrtc_pkg::SRC_RC_B: srcPulse = pinEdge[3];
			bcrtc_pkg::SRC_FAST: srcPulse = fastTick;
			default: srcPulse = 1'b0;
		endcase
		rtcPulse = srcPulse && runOk;
	end

	// pinS1 is read by pinS2 only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinS1 <= 5'h00;
			pinS2 <= 5'h00;
			pinS3 <= 5'h00;
			fastDiv <= 5'h00;
			rtcRunning <= 1'b0;
		end else if (ce) begin
			pinS1 <= {fastPin, rcBPin, rcAPin, xtalPin, refPin};
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			fastDiv <= next_fastDiv;
			rtcRunning <= runOk;
		end
	end

	// prescaler: calibration mask, shift swallow, reference alignment
	always_comb begin
		calMasked = rtcPulse && (calCnt[10:0] == bcrtc_pkg::CAL_SLOT)
			&& (calCnt[19:11] < calibMask);
		next_calCnt = rtcPulse ? calCnt + 20'h00001 : calCnt;
		livePulse = rtcPulse && !calMasked;
		swallow = livePulse && (shiftPend != 15'h0000);
		effPulse = livePulse && (shiftPend == 15'h0000);
		next_shiftPend = shiftPend;
		if (swallow) begin
			next_shiftPend = shiftPend - 15'h0001;
		end else if (shiftReq && shiftPend == 15'h0000) begin
			next_shiftPend = shiftAmount;
		end
		next_shiftBusy = (next_shiftPend != 15'h0000);
		refTop = ref60 ? bcrtc_pkg::REF_TOP_60 : bcrtc_pkg::REF_TOP_50;
		refSec = refEnable && pinEdge[0] && (refCnt == refTop);
		next_refCnt = refCnt;
		if (!refEnable || refSec) begin
			next_refCnt = 6'h00;
		end else if (pinEdge[0]) begin
			next_refCnt = refCnt + 6'h01;
		end
		lateEdge = preDiv - bcrtc_pkg::REF_WIN;
		ssLate = subSec > lateEdge;
		refForce = refSec && (subSec < bcrtc_pkg::REF_WIN);
		next_refLocked = refEnable && (refSec ? (refForce || ssLate) : refLocked);
		next_subSec = subSec;
		next_secTick = 1'b0;
		if (calLoad) begin
			next_subSec = preDiv;
		end else if (refForce) begin
			next_subSec = preDiv;
			next_secTick = 1'b1;
		end else if (effPulse) begin
			if (subSec == 15'h0000) begin
				next_subSec = preDiv;
				next_secTick = 1'b1;
			end else begin
				next_subSec = subSec - 15'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			calCnt <= 20'h00000;
			shiftPend <= 15'h0000;
			shiftBusy <= 1'b0;
			refCnt <= 6'h00;
			refLocked <= 1'b0;
			subSec <= bcrtc_pkg::PREDIV_RST;
			secTick <= 1'b0;
		end else if (ce) begin
			calCnt <= next_calCnt;
			shiftPend <= next_shiftPend;
			shiftBusy <= next_shiftBusy;
			refCnt <= next_refCnt;
			refLocked <= next_refLocked;
			subSec <= next_subSec;
			secTick <= next_secTick;
		end
	end

	// calendar carry chain, one step per second tick
	always_comb begin
		next_cal = calOut;
		rollDay = 1'b0;
		dayTop = daysIn(calOut.month, calOut.year);
		if (calLoad) begin
			next_cal = calIn;
		end else if (secTick) begin
			next_cal.sec = bcdInc(calOut.sec);
			if (calOut.sec == bcrtc_pkg::SEC_TOP) begin
				next_cal.sec = bcrtc_pkg::BCD_ZERO;
				next_cal.min = bcdInc(calOut.min);
				if (calOut.min == bcrtc_pkg::SEC_TOP) begin
					next_cal.min = bcrtc_pkg::BCD_ZERO;
					next_cal.hour = bcdInc(calOut.hour);
					if (!hour12 && calOut.hour == bcrtc_pkg::HOUR24_TOP) begin
						next_cal.hour = bcrtc_pkg::BCD_ZERO;
						rollDay = 1'b1;
					end
					if (hour12 && calOut.hour == bcrtc_pkg::HOUR12_TOP) begin
						next_cal.hour = bcrtc_pkg::BCD_ONE;
					end
					if (hour12 && calOut.hour == bcrtc_pkg::HOUR_ELEVEN) begin
						next_cal.pm = !calOut.pm;
						rollDay = calOut.pm;
					end
				end
			end
			if (rollDay) begin
				next_cal.wday = (calOut.wday == bcrtc_pkg::WDAY_TOP) ? bcrtc_pkg::WDAY_ONE
					: calOut.wday + 3'h1;
				next_cal.date = bcdInc(calOut.date);
				if (calOut.date == dayTop) begin
					next_cal.date = bcrtc_pkg::BCD_ONE;
					next_cal.month = bcdInc(calOut.month);
					if (calOut.month == bcrtc_pkg::MONTH_TOP) begin
						next_cal.month = bcrtc_pkg::BCD_ONE;
						next_cal.year = (calOut.year == bcrtc_pkg::YEAR_TOP)
							? bcrtc_pkg::BCD_ZERO : bcdInc(calOut.year);
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			calOut <= bcrtc_pkg::CAL_RST;
		end else if (ce) begin
			calOut <= next_cal;
		end
	end

	bcrtc_in_filter #(.CNT_W(FILT_W)) u_tampFilt (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.pinIn(tamperPin),
		.filtSel(tampFilt),
		.evt(tampEvt)
	);

	bcrtc_in_filter #(.CNT_W(FILT_W)) u_tsFilt (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.pinIn(tsPin),
		.filtSel(tsFilt),
		.evt(tsEvt)
	);

	bcrtc_bkp_mem #(.WORDS(BKP_WORDS), .AW(bcrtc_pkg::BKP_AW), .DW(bcrtc_pkg::BKP_DW)) u_bkp (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.wrEn(bkpWrEn),
		.wrAddr(bkpWrAddr),
		.wrData(bkpWrData),
		.rdAddr(bkpRdAddr),
		.rdData(bkpRdData)
	);

	// events: alarms compare the calendar one cycle after it steps; sets beat clears
	always_comb begin
		next_calStep = secTick && !calLoad;
		alarmHit[0] = calStep && alarmEn[0] && almMatch(alarmA, calOut);
		alarmHit[1] = calStep && alarmEn[1] && almMatch(alarmB, calOut);
		next_alarmFlag = alarmHit | (alarmFlag & ~alarmClear);
		tsTrig = tsEvt || tampEvt || (battMode && !battD);
		next_tsCal = tsTrig ? calOut : tsCal;
		next_tsSubSec = tsTrig ? subSec : tsSubSec;
		next_tsFlag = tsTrig || (tsFlag && !tsClear);
		next_tsOvf = (tsTrig && tsFlag) || (tsOvf && !tsClear);
		next_tampFlag = tampEvt || (tampFlag && !tampClear);
		next_wuPre = rtcPulse ? wuPre + 4'h1 : wuPre;
		case (wuSel)
			3'h0: wuTick = rtcPulse && (wuPre == 4'hF);
			3'h1: wuTick = rtcPulse && (wuPre[2:0] == 3'h7);
			3'h2: wuTick = rtcPulse && (wuPre[1:0] == 2'h3);
			3'h3: wuTick = rtcPulse && wuPre[0];
			default: wuTick = secTick;
		endcase
		wuReloadFull = {wuSel[2] && wuSel[1], wuReload};
		wuHit = 1'b0;
		next_wuCnt = wuCnt;
		if (!wuEnable) begin
			next_wuCnt = wuReloadFull;
		end else if (wuTick) begin
			if (wuCnt == 17'h00000) begin
				next_wuCnt = wuReloadFull;
				wuHit = 1'b1;
			end else begin
				next_wuCnt = wuCnt - 17'h00001;
			end
		end
		next_wuFlag = wuHit || (wuFlag && !wuClear);
		evFlags = {tampFlag, tsFlag, wuFlag, alarmFlag};
		next_wakeReq = |(evFlags & eventIe);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			calStep <= 1'b0;
			alarmFlag <= 2'b00;
			battD <= 1'b0;
			tsCal <= bcrtc_pkg::CAL_RST;
			tsSubSec <= 15'h0000;
			tsFlag <= 1'b0;
			tsOvf <= 1'b0;
			tampFlag <= 1'b0;
			wuPre <= 4'h0;
			wuCnt <= 17'h00000;
			wuFlag <= 1'b0;
			wakeReq <= 1'b0;
		end else if (ce) begin
			calStep <= next_calStep;
			alarmFlag <= next_alarmFlag;
			battD <= battMode;
			tsCal <= next_tsCal;
			tsSubSec <= next_tsSubSec;
			tsFlag <= next_tsFlag;
			tsOvf <= next_tsOvf;
			tampFlag <= next_tampFlag;
			wuPre <= next_wuPre;
			wuCnt <= next_wuCnt;
			wuFlag <= next_wuFlag;
			wakeReq <= next_wakeReq;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_sec_wrap: assert property ((ce && secTick && !calLoad && calOut.sec == 8'h59)
		|=> calOut.sec == 8'h00) else $error("seconds did not wrap");
	chk_month_end: assert property ((ce && secTick && !calLoad && rollDay
		&& calOut.date == dayTop) |=> calOut.date == 8'h01)
		else $error("month end missed");
	chk_shift_swallow: assert property ((ce && swallow && !calLoad && !refForce)
		|=> subSec == $past(subSec) && shiftPend == $past(shiftPend) - 15'h0001)
		else $error("shift pulse not swallowed");
	chk_ref_align: assert property ((ce && refForce && !calLoad)
		|=> secTick && subSec == $past(preDiv)) else $error("reference not aligned");
	chk_calib_mask: assert property ((ce && calMasked && !calLoad && !refForce)
		|=> subSec == $past(subSec)) else $error("calibration pulse counted");
	chk_ts_capture: assert property ((ce && tsTrig)
		|=> tsFlag && tsCal == $past(calOut)) else $error("timestamp not captured");
	chk_wut_reload: assert property ((ce && wuEnable && wuTick && wuCnt == 17'h00000)
		|=> wuFlag && wuCnt == $past(wuReloadFull)) else $error("wakeup reload wrong");
	chk_fast_div: assert property ((clkSel == bcrtc_pkg::SRC_FAST && runOk && pinEdge[4]
		&& fastDiv == 5'h1F) |-> rtcPulse) else $error("divided source missing");
	chk_rc_stop: assert property ((battMode && clkSel != bcrtc_pkg::SRC_XTAL)
		|-> !rtcPulse ##1 !rtcRunning || !ce) else $error("rc ran on battery");
	chk_wake_req: assert property ((ce && (|(evFlags & eventIe)))
		|=> wakeReq) else $error("wakeup not requested");
	chk_sec_tick: assert property ((ce && effPulse && subSec == 15'h0000 && !calLoad
		&& !refForce) |=> secTick && subSec == $past(preDiv))
		else $error("second tick missed");
	chk_alarm_set: assert property ((ce && alarmHit[0]) |=> alarmFlag[0])
		else $error("alarm flag not set");

	cov_day_roll: cover property (ce && secTick && rollDay);
	cov_alarm_hit: cover property (ce && alarmHit[1]);
	cov_ts_trig: cover property (ce && tsTrig);
	cov_wut_hit: cover property (ce && wuHit);
endmodule
`default_nettype wire

// file: sim/bcrtc_tb_top.sv
`default_nettype none
module bcrtc_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst, ce, refPin, tamperPin, tsPin, battMode, shutdownMode, calLoad, hour12;
	logic [3:0] srcPins;
	bcrtc_pkg::bcrtc_src_t clkSel;
	logic [14:0] preDiv, shiftAmount, subSec, tsSubSec;
	logic shiftReq, refEnable, ref60, tsClear, tampClear, wuEnable, wuClear, bkpWrEn;
	logic [8:0] calibMask;
	logic [1:0] tampFilt, tsFilt, alarmEn, alarmClear, alarmFlag;
	logic [2:0] wuSel;
	logic [15:0] wuReload;
	logic [4:0] eventIe, bkpWrAddr, bkpRdAddr;
	logic [31:0] bkpWrData, bkpRdData;
	bcrtc_pkg::bcrtc_cal_t calIn, calOut, tsCal;
	bcrtc_pkg::bcrtc_alarm_t alarmA, alarmB;
	logic tsFlag, tsOvf, tampFlag, wuFlag, wakeReq, rtcRunning, shiftBusy, refLocked;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;

	bcrtc_top uut (.core_clk(core_clk), .rst(rst), .ce(ce), .xtalPin(srcPins[0]),
		.rcAPin(srcPins[1]), .rcBPin(srcPins[2]), .fastPin(srcPins[3]), .refPin(refPin),
		.tamperPin(tamperPin), .tsPin(tsPin), .clkSel(clkSel), .battMode(battMode),
		.shutdownMode(shutdownMode), .preDiv(preDiv), .calLoad(calLoad), .calIn(calIn),
		.hour12(hour12), .shiftReq(shiftReq), .shiftAmount(shiftAmount), .calibMask(calibMask),
		.refEnable(refEnable), .ref60(ref60), .tampFilt(tampFilt), .tsFilt(tsFilt),
		.tsClear(tsClear), .tampClear(tampClear), .wuEnable(wuEnable), .wuSel(wuSel),
		.wuReload(wuReload), .wuClear(wuClear), .alarmEn(alarmEn), .alarmA(alarmA),
		.alarmB(alarmB), .alarmClear(alarmClear), .eventIe(eventIe), .bkpWrEn(bkpWrEn),
		.bkpWrAddr(bkpWrAddr), .bkpWrData(bkpWrData), .bkpRdAddr(bkpRdAddr),
		.bkpRdData(bkpRdData), .calOut(calOut), .subSec(subSec), .tsCal(tsCal),
		.tsSubSec(tsSubSec), .tsFlag(tsFlag), .tsOvf(tsOvf), .tampFlag(tampFlag),
		.wuFlag(wuFlag), .alarmFlag(alarmFlag), .wakeReq(wakeReq), .rtcRunning(rtcRunning),
		.shiftBusy(shiftBusy), .refLocked(refLocked));

	// 20 MHz system clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// hang guard: the whole sequence needs a few thousand cycles at most
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cal(input bcrtc_pkg::bcrtc_cal_t got, input bcrtc_pkg::bcrtc_cal_t exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic bcrtc_pkg::bcrtc_cal_t mk(input logic [7:0] y, mo, d, input logic [2:0] w,
		input logic p, input logic [7:0] h, mi, s);
		mk = '{year: y, month: mo, date: d, wday: w, pm: p, hour: h, min: mi, sec: s};
	endfunction

	task automatic tick(input int n);
		repeat (n) begin
			srcPins = 4'hF;
			repeat (2) @(negedge core_clk);
			srcPins = 4'h0;
			repeat (2) @(negedge core_clk);
		end
		// sync, edge stage, tick, step and flag stages must all land
		repeat (6) @(negedge core_clk);
	endtask

	task automatic load(input bcrtc_pkg::bcrtc_cal_t c);
		calIn = c;
		calLoad = 1'b1;
		@(negedge core_clk);
		calLoad = 1'b0;
		@(negedge core_clk);
	endtask

	// one second is preDiv + 1 pulses, preDiv is 3 here
	task automatic roll(input bcrtc_pkg::bcrtc_cal_t a, input bcrtc_pkg::bcrtc_cal_t e);
		load(a);
		tick(4);
		chk_cal(calOut, e);
	endtask

	task automatic bkp_wr(input logic [4:0] a, input logic [31:0] d);
		bkpWrAddr = a;
		bkpWrData = d;
		bkpWrEn = 1'b1;
		@(negedge core_clk);
		bkpWrEn = 1'b0;
	endtask

	task automatic bkp_rd(input logic [4:0] a, input logic [31:0] e);
		bkpRdAddr = a;
		repeat (2) @(negedge core_clk);
		chk(bkpRdData, e);
	endtask

	task automatic pin_pulse(input int which);
		if (which == 0) tsPin = 1'b1;
		else tamperPin = 1'b1;
		repeat (6) @(negedge core_clk);
		tsPin = 1'b0;
		tamperPin = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask

	// main sequence; every input changes on the falling edge
	initial begin
		{ce, refPin, tamperPin, tsPin, battMode, shutdownMode, calLoad, hour12} = 8'h80;
		srcPins = 4'h0;
		clkSel = bcrtc_pkg::SRC_XTAL;
		{preDiv, shiftAmount, shiftReq, refEnable, ref60} = '0;
		{calibMask, tampFilt, tsFilt, tsClear, tampClear, wuEnable, wuClear} = '0;
		{wuSel, wuReload, alarmEn, alarmClear, eventIe, bkpWrEn} = '0;
		{bkpWrAddr, bkpRdAddr, bkpWrData} = '0;
		calIn = bcrtc_pkg::CAL_RST;
		alarmA = '0;
		alarmB = '0;
		rst = 1'b1;
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		chk_cal(calOut, bcrtc_pkg::CAL_RST);
		chk(subSec, 32'h00007FFF);
		chk({tsFlag, tsOvf, tampFlag, wuFlag, alarmFlag, wakeReq, rtcRunning}, 32'h0);
		$display("reset test done");
		bkp_wr(5'h03, 32'hA5A50F0F);
		bkp_wr(5'h13, 32'h0000BEEF);
		bkp_wr(5'h14, 32'h12345678);
		bkp_rd(5'h03, 32'hA5A50F0F);
		bkp_rd(5'h13, 32'h0000BEEF);
		bkp_rd(5'h14, 32'h00000000);
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		bkp_rd(5'h03, 32'hA5A50F0F);
		bkp_rd(5'h13, 32'h0000BEEF);
		$display("backup test done");
		preDiv = 15'h0003;
		roll(mk(8'h24, 8'h02, 8'h28, 3'h3, 0, 8'h23, 8'h59, 8'h59),
			mk(8'h24, 8'h02, 8'h29, 3'h4, 0, 8'h00, 8'h00, 8'h00));
		roll(mk(8'h23, 8'h02, 8'h28, 3'h3, 0, 8'h23, 8'h59, 8'h59),
			mk(8'h23, 8'h03, 8'h01, 3'h4, 0, 8'h00, 8'h00, 8'h00));
		roll(mk(8'h24, 8'h04, 8'h30, 3'h2, 0, 8'h23, 8'h59, 8'h59),
			mk(8'h24, 8'h05, 8'h01, 3'h3, 0, 8'h00, 8'h00, 8'h00));
		roll(mk(8'h99, 8'h12, 8'h31, 3'h7, 0, 8'h23, 8'h59, 8'h59),
			mk(8'h00, 8'h01, 8'h01, 3'h1, 0, 8'h00, 8'h00, 8'h00));
		hour12 = 1'b1;
		roll(mk(8'h24, 8'h01, 8'h15, 3'h3, 0, 8'h11, 8'h59, 8'h59),
			mk(8'h24, 8'h01, 8'h15, 3'h3, 1, 8'h12, 8'h00, 8'h00));
		roll(mk(8'h24, 8'h01, 8'h15, 3'h3, 1, 8'h11, 8'h59, 8'h59),
			mk(8'h24, 8'h01, 8'h16, 3'h4, 0, 8'h12, 8'h00, 8'h00));
		hour12 = 1'b0;
		$display("calendar test done");
		load(bcrtc_pkg::CAL_RST);
		chk(subSec, 32'h3);
		tick(1);
		chk(subSec, 32'h2);
		// a requested shift must delay the next second by exactly the amount
		load(bcrtc_pkg::CAL_RST);
		shiftAmount = 15'h0002;
		shiftReq = 1'b1;
		@(negedge core_clk);
		shiftReq = 1'b0;
		chk(shiftBusy, 1);
		tick(4);
		chk(calOut.sec, 8'h00);
		tick(2);
		chk(calOut.sec, 8'h01);
		chk(shiftBusy, 0);
		$display("shift test done");
		alarmA = '{skip: 4'hE, date: 8'h01, pm: 1'b0, hour: 8'h00, min: 8'h00, sec: 8'h01};
		alarmB = '{skip: 4'hE, date: 8'h01, pm: 1'b0, hour: 8'h00, min: 8'h00, sec: 8'h02};
		alarmEn = 2'b11;
		eventIe = 5'h01;
		load(bcrtc_pkg::CAL_RST);
		tick(4);
		chk(alarmFlag, 2'b01);
		chk(wakeReq, 1);
		tick(4);
		chk(alarmFlag, 2'b11);
		alarmClear = 2'b11;
		@(negedge core_clk);
		alarmClear = 2'b00;
		repeat (2) @(negedge core_clk);
		chk({alarmFlag, wakeReq}, 3'b000);
		alarmEn = 2'b00;
		$display("alarm test done");
		wuSel = 3'h4;
		wuEnable = 1'b1;
		@(negedge core_clk);
		chk(wuFlag, 0);
		tick(4);
		chk(wuFlag, 1);
		$display("wakeup timer test done");
		pin_pulse(0);
		chk(tsFlag, 1);
		chk_cal(tsCal, calOut);
		chk(tsSubSec, subSec);
		chk(tsOvf, 0);
		pin_pulse(0);
		chk(tsOvf, 1);
		tsClear = 1'b1;
		@(negedge core_clk);
		tsClear = 1'b0;
		pin_pulse(1);
		chk({tampFlag, tsFlag}, 2'b11);
		{tsClear, tampClear} = 2'b11;
		@(negedge core_clk);
		{tsClear, tampClear} = 2'b00;
		$display("event test done");
		clkSel = bcrtc_pkg::SRC_RC_A;
		battMode = 1'b1;
		repeat (6) @(negedge core_clk);
		chk({rtcRunning, tsFlag}, 2'b01);
		load(bcrtc_pkg::CAL_RST);
		tick(4);
		chk(calOut.sec, 8'h00);
		battMode = 1'b0;
		tick(4);
		chk({rtcRunning, calOut.sec}, 9'h101);
		clkSel = bcrtc_pkg::SRC_XTAL;
		{battMode, shutdownMode} = 2'b11;
		tick(4);
		chk({rtcRunning, calOut.sec}, 9'h102);
		ce = 1'b0;
		tick(4);
		chk(calOut.sec, 8'h02);
		ce = 1'b1;
		$display("clock source test done");
		// fiftieth reference edge with a small remainder forces the second
		refEnable = 1'b1;
		load(bcrtc_pkg::CAL_RST);
		repeat (50) begin
			refPin = 1'b1;
			repeat (2) @(negedge core_clk);
			refPin = 1'b0;
			repeat (2) @(negedge core_clk);
		end
		repeat (6) @(negedge core_clk);
		chk({refLocked, calOut.sec}, 9'h101);
		refEnable = 1'b0;
		$display("reference test done");
		// the pulse counter restarts at reset, so the first pulse falls in the mask slot
		rst = 1'b1;
		{battMode, shutdownMode} = 2'b00;
		calibMask = 9'h001;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		load(bcrtc_pkg::CAL_RST);
		tick(1);
		chk(subSec, 32'h3);
		tick(1);
		chk(subSec, 32'h2);
		$display("calibration test done");
		end_sim();
	end
endmodule
`default_nettype wire
